// file: hw/adcsq_pkg.sv
// Package for the converter sequencer: register map, field positions,
// timing constants, state encoding and the state record.
// Assumes an 8-bit register port and a 40 MHz bus clock.
package adcsq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int MCLK_HZ = 40_000_000;
	localparam int CONV_HZ = 2_000_000;
	localparam int CONV_TIME_NS = 14000;
	localparam int RES_BITS = 10;
	localparam int DIV = MCLK_HZ / CONV_HZ;
	localparam int CONV_CLKS = CONV_TIME_NS * (CONV_HZ / 1000) / 1_000_000;
	localparam logic [4:0] DIV_LAST = 5'(DIV - 1);
	localparam logic [4:0] DIV_HALF = 5'(DIV / 2 - 1);
	localparam logic [4:0] SAMPLE_LAST = 5'(CONV_CLKS - RES_BITS - 1);
	localparam logic [3:0] BIT_MSB = 4'(RES_BITS - 1);
	localparam logic [3:0] BIT_LSB10 = 4'h0;
	localparam logic [3:0] BIT_LSB8 = 4'h2;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_START = 3'h1;
	localparam logic [2:0] ADDR_STS = 3'h2;
	localparam logic [2:0] ADDR_MASK = 3'h3;
	localparam logic [2:0] ADDR_RES_HI = 3'h4;
	localparam logic [2:0] ADDR_RES_LO = 3'h5;
	localparam logic [2:0] ADDR_PIN_EN = 3'h6;

	localparam int CTRL_PU = 7;
	localparam int CTRL_RES10 = 6;
	localparam int CTRL_LEFT = 5;
	localparam int CTRL_SGN = 4;
	localparam int CTRL_CONT = 3;
	localparam int STS_DONE = 0;
	localparam int STS_ABORT = 1;
	localparam int STS_BUSY = 6;
	localparam int STS_ACTIVE = 7;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PIN_EN_RESET = 8'h00;
	localparam logic [1:0] EV_RESET = 2'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ADCSQ_IDLE,
		ADCSQ_SAMPLE,
		ADCSQ_CONV
	} adcsq_phase_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [2:0] chan;
		logic [7:0] pin_en;
		logic [1:0] sts;
		logic [1:0] msk;
		logic [15:0] result;
		adcsq_phase_t phase;
		logic [4:0] div;
		logic [4:0] tick;
		logic [3:0] bit_idx;
		logic [9:0] sar;
		logic conv_clk;
		logic sample;
		logic analog_en;
		logic irq;
		logic [7:0] rdata;
	} adcsq_state_t;

endpackage

// file: hw/adcsq_core.sv
// Sequencer and low-power control of an eight-channel SAR converter.
// Assumes a comparator result that is valid one conversion clock after
// the trial code is driven, and a stop level from the system controller.
//
// Overview of operation
// - Stop mode gates the conversion clock and switches analog off.
// - Entering stop aborts any single or continuous conversion.
// - After stop no conversion starts itself; registers keep values.
// - Leaving stop reactivates only if power-up was set beforehand.
// - Writing power-up bit zero puts the block in power-down.
// - Power-down gates conversion clock, disables analog, keeps supply.
// - Entering power-down aborts the conversion in progress.
// - Setting power-up bit returns the block to the active state.
// - Registers stay readable and writable during power-down.
// - Power-up bit resets to zero, so reset lands in power-down.
// - A 10-bit conversion takes 14.0 us at a 2 MHz conversion clock.
// - A left-justified signed result mode is offered.
// - Each conversion end sets a done flag and may interrupt.
// - The input multiplexer selects one of eight analog channels.
// - Software chooses single or continuous conversion.
// - Each of eight shared pins is set to GPIO or analog alone.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps

module adcsq_core (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic stop_mode,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cmp_in,
	output logic [9:0] dac_code,
	output logic [2:0] mux_sel,
	output logic sample_hold,
	output logic conv_clk,
	output logic analog_en,
	output logic [7:0] pin_analog,
	output logic irq
);

	// ****************************************
	// State
	// ****************************************
	adcsq_pkg::adcsq_state_t s_q;
	adcsq_pkg::adcsq_state_t s_d;

	logic active;
	logic ck;
	logic done_ev;
	logic abort_ev;
	logic wr_ctrl;
	logic wr_start;
	logic wr_sts;
	logic wr_mask;
	logic wr_pin;
	logic [1:0] clr;
	logic [3:0] lsb;
	logic [7:0] sts_rd;

	// ****************************************
	// Result formatting
	// ****************************************
	// The 8-bit result is the upper eight trial bits, so in left-justified
	// mode one shift covers both resolutions.
	function automatic logic [15:0] adcsq_format(
		input logic [9:0] sar,
		input logic [7:0] ctrl
	);
		logic [9:0] v;
		logic [15:0] r;
		v = sar;
		if (!ctrl[adcsq_pkg::CTRL_RES10]) begin
			v[1:0] = 2'h0;
		end
		if (ctrl[adcsq_pkg::CTRL_LEFT]) begin
			r = {v, 6'h00};
			// Offset binary to two's complement: flip the sign bit
			if (ctrl[adcsq_pkg::CTRL_SGN]) begin
				r[15] = ~r[15];
			end
		end else if (ctrl[adcsq_pkg::CTRL_RES10]) begin
			r = {6'h00, v};
		end else begin
			r = {8'h00, v[9:2]};
		end
		return r;
	endfunction

	// ****************************************
	// Register decode
	// ****************************************
	// Map: control, start and channel, status (done and abort are
	// write-one-to-clear, busy and active read only), mask, result
	// high and low bytes, pin select. Address 7 reads zero.
	always_comb begin
		wr_ctrl = 1'b0;
		wr_start = 1'b0;
		wr_sts = 1'b0;
		wr_mask = 1'b0;
		wr_pin = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				adcsq_pkg::ADDR_CTRL: begin
					wr_ctrl = 1'b1;
				end
				adcsq_pkg::ADDR_START: begin
					wr_start = 1'b1;
				end
				adcsq_pkg::ADDR_STS: begin
					wr_sts = 1'b1;
				end
				adcsq_pkg::ADDR_MASK: begin
					wr_mask = 1'b1;
				end
				adcsq_pkg::ADDR_PIN_EN: begin
					wr_pin = 1'b1;
				end
				default: begin
					wr_ctrl = 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Power state and conversion tick
	// ****************************************
	// Stop overrides power-up without touching the bit, so leaving
	// stop resumes only what software had switched on
	always_comb begin
		active = s_q.ctrl[adcsq_pkg::CTRL_PU] & ~stop_mode;
		ck = active && (s_q.div == adcsq_pkg::DIV_LAST);
		lsb = s_q.ctrl[adcsq_pkg::CTRL_RES10] ?
			adcsq_pkg::BIT_LSB10 : adcsq_pkg::BIT_LSB8;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		done_ev = 1'b0;
		abort_ev = 1'b0;

		// Conversion clock divider, held in reset while inactive
		if (!active) begin
			s_d.div = 5'h00;
			s_d.conv_clk = 1'b0;
		end else if (s_q.div == adcsq_pkg::DIV_LAST) begin
			s_d.div = 5'h00;
			s_d.conv_clk = 1'b1;
		end else begin
			s_d.div = s_q.div + 5'h01;
			if (s_q.div == adcsq_pkg::DIV_HALF) begin
				s_d.conv_clk = 1'b0;
			end
		end

		// Analog circuitry is off whenever the block is inactive
		s_d.analog_en = active;

		// Register writes; they are honoured in every power state
		if (wr_ctrl) begin
			s_d.ctrl = reg_wdata;
		end
		if (wr_mask) begin
			s_d.msk = reg_wdata[1:0];
		end
		if (wr_pin) begin
			s_d.pin_en = reg_wdata;
		end

		// Conversion sequence
		case (s_q.phase)
			adcsq_pkg::ADCSQ_IDLE: begin
				s_d.sample = 1'b0;
			end

			adcsq_pkg::ADCSQ_SAMPLE: begin
				if (ck) begin
					if (s_q.tick == adcsq_pkg::SAMPLE_LAST) begin
						s_d.phase = adcsq_pkg::ADCSQ_CONV;
						s_d.sample = 1'b0;
						s_d.tick = 5'h00;
						s_d.bit_idx = adcsq_pkg::BIT_MSB;
						s_d.sar = 10'h200;
					end else begin
						s_d.tick = s_q.tick + 5'h01;
					end
				end
			end

			adcsq_pkg::ADCSQ_CONV: begin
				// Sample phase plus one clock per bit gives the conversion time
				if (ck) begin
					s_d.sar[s_q.bit_idx] = cmp_in;
					if (s_q.bit_idx == lsb) begin
						done_ev = 1'b1;
						s_d.result = adcsq_format(s_d.sar, s_q.ctrl);
						if (s_q.ctrl[adcsq_pkg::CTRL_CONT]) begin
							// Continuous mode resamples the same channel
							s_d.phase = adcsq_pkg::ADCSQ_SAMPLE;
							s_d.sample = 1'b1;
							s_d.tick = 5'h00;
						end else begin
							s_d.phase = adcsq_pkg::ADCSQ_IDLE;
						end
					end else begin
						s_d.bit_idx = s_q.bit_idx - 4'h1;
						s_d.sar[s_q.bit_idx - 4'h1] = 1'b1;
					end
				end
			end

			default: begin
				s_d.phase = adcsq_pkg::ADCSQ_IDLE;
				s_d.sample = 1'b0;
			end
		endcase

		// A write to the start register selects the channel and
		// restarts the sequence; the restart is ignored while inactive
		if (wr_start) begin
			s_d.chan = reg_wdata[2:0];
			if (active) begin
				s_d.phase = adcsq_pkg::ADCSQ_SAMPLE;
				s_d.sample = 1'b1;
				s_d.tick = 5'h00;
			end
		end

		// Losing power-up or entering stop throws the conversion away.
		// Nothing restarts on its own afterwards: the phase stays idle
		// until software writes the start register again.
		if (!active && (s_q.phase != adcsq_pkg::ADCSQ_IDLE)) begin
			s_d.phase = adcsq_pkg::ADCSQ_IDLE;
			s_d.sample = 1'b0;
			s_d.tick = 5'h00;
			abort_ev = 1'b1;
		end

		// Sticky events, write one to clear; a new event beats the clear
		clr = wr_sts ? reg_wdata[1:0] : 2'h0;
		s_d.sts[adcsq_pkg::STS_DONE] = (s_q.sts[adcsq_pkg::STS_DONE]
			& ~clr[adcsq_pkg::STS_DONE]) | done_ev;
		s_d.sts[adcsq_pkg::STS_ABORT] = (s_q.sts[adcsq_pkg::STS_ABORT]
			& ~clr[adcsq_pkg::STS_ABORT]) | abort_ev;
		s_d.irq = |(s_d.sts & s_d.msk);

		// Read side, answered in the following cycle
		sts_rd = 8'h00;
		sts_rd[1:0] = s_q.sts;
		sts_rd[adcsq_pkg::STS_BUSY] = (s_q.phase != adcsq_pkg::ADCSQ_IDLE);
		sts_rd[adcsq_pkg::STS_ACTIVE] = active;
		if (reg_rd) begin
			case (reg_addr)
				adcsq_pkg::ADDR_CTRL: begin
					s_d.rdata = s_q.ctrl;
				end
				adcsq_pkg::ADDR_START: begin
					s_d.rdata = {5'h00, s_q.chan};
				end
				adcsq_pkg::ADDR_STS: begin
					s_d.rdata = sts_rd;
				end
				adcsq_pkg::ADDR_MASK: begin
					s_d.rdata = {6'h00, s_q.msk};
				end
				adcsq_pkg::ADDR_RES_HI: begin
					s_d.rdata = s_q.result[15:8];
				end
				adcsq_pkg::ADDR_RES_LO: begin
					s_d.rdata = s_q.result[7:0];
				end
				adcsq_pkg::ADDR_PIN_EN: begin
					s_d.rdata = s_q.pin_en;
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Reset leaves power-up clear, so the block starts powered down
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q.ctrl <= adcsq_pkg::CTRL_RESET;
			s_q.chan <= 3'h0;
			s_q.pin_en <= adcsq_pkg::PIN_EN_RESET;
			s_q.sts <= adcsq_pkg::EV_RESET;
			s_q.msk <= adcsq_pkg::EV_RESET;
			s_q.result <= 16'h0000;
			s_q.phase <= adcsq_pkg::ADCSQ_IDLE;
			s_q.div <= 5'h00;
			s_q.tick <= 5'h00;
			s_q.bit_idx <= 4'h0;
			s_q.sar <= 10'h000;
			s_q.conv_clk <= 1'b0;
			s_q.sample <= 1'b0;
			s_q.analog_en <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.rdata <= 8'h00;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = s_q.rdata;
	assign dac_code = s_q.sar;
	assign mux_sel = s_q.chan;
	assign sample_hold = s_q.sample;
	assign conv_clk = s_q.conv_clk;
	assign analog_en = s_q.analog_en;
	assign pin_analog = s_q.pin_en;
	assign irq = s_q.irq;

endmodule

// file: tb/adcsq_core_sva.sv
// Port checker for the converter sequencer.
// Assumes it is bound to adcsq_core and sees only its ports.
`timescale 1ns/10ps
module adcsq_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic stop_mode,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_hold,
	input wire logic conv_clk,
	input wire logic analog_en,
	input wire logic [7:0] pin_analog
);
	// ****************************************
	// Shadow of written control values
	// ****************************************
	logic pu_q;
	logic [7:0] pin_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pu_q <= 1'b0;
			pin_q <= 8'h00;
		end else if (reg_wr && clk_en) begin
			if (reg_addr == adcsq_pkg::ADDR_CTRL)
				pu_q <= reg_wdata[adcsq_pkg::CTRL_PU];
			if (reg_addr == adcsq_pkg::ADDR_PIN_EN)
				pin_q <= reg_wdata;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	pd_analog_a: assert property (!pu_q && $past(!pu_q) |-> !analog_en)
		else $error("analog on while powered down");
	stop_analog_a: assert property (stop_mode && $past(stop_mode) |-> !analog_en)
		else $error("analog on in stop");
	pd_clk_a: assert property (!analog_en && $past(!analog_en) |-> !conv_clk)
		else $error("conversion clock runs while inactive");
	pd_sample_a: assert property (!analog_en && $past(!analog_en) |-> !sample_hold)
		else $error("sampling while inactive");
	stop_abort_a: assert property ($rose(stop_mode) ##1 stop_mode |=> !sample_hold && !conv_clk)
		else $error("conversion survives stop");
	no_self_a: assert property ($fell(stop_mode) && !reg_wr |=> !sample_hold)
		else $error("conversion started by itself after stop");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	pin_sel_a: assert property ($stable(pin_q) |-> pin_analog == pin_q)
		else $error("pin select differs from written value");
endmodule

bind adcsq_core adcsq_chk chk (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
	.stop_mode(stop_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_hold(sample_hold), .conv_clk(conv_clk),
	.analog_en(analog_en), .pin_analog(pin_analog));

// file: tb/adcsq_core_bench.sv
// Bench for the converter sequencer: register tasks, SAR input model.
// Assumes one 40 MHz clock and no partner model.
`timescale 1ns/10ps
module adcsq_core_bench;
	logic mclk = 1'b0, rstn = 1'b0, clk_en = 1'b1, stop_mode = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cmp_in = 1'b0;
	logic [2:0] reg_addr = 3'h0, mux_sel;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, pin_analog, p;
	logic [9:0] dac_code;
	logic sample_hold, conv_clk, analog_en, irq;
	logic [7:0] modes[6] = '{8'hc0, 8'h80, 8'he0, 8'ha0, 8'hf0, 8'hb0};
	int error_cnt = 0, n_compared = 0, cyc = 0, vin = 0, n;

	adcsq_core uut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .stop_mode(stop_mode),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cmp_in(cmp_in), .dac_code(dac_code), .mux_sel(mux_sel),
		.sample_hold(sample_hold), .conv_clk(conv_clk), .analog_en(analog_en),
		.pin_analog(pin_analog), .irq(irq));

	always #12.5 mclk = ~mclk;
	// Comparator: analog input at or above the trial code
	always @(posedge mclk) cmp_in <= (vin >= int'(dac_code));
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rc(string nm, logic [2:0] a, logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe: take them at its closing edge
		@(posedge mclk);
		chk(nm, 16'(reg_rdata), 16'(e));
	endtask
	task automatic wirq();
		n = 0;
		while (irq !== 1'b1 && n < 800) begin
			@(posedge mclk);
			n++;
		end
	endtask
	// Expected result word; 8-bit trials leave the two low code bits zero
	function automatic logic [15:0] fmt(logic [7:0] c);
		logic [9:0] r;
		r = c[6] ? 10'(vin) : 10'(vin) & 10'h3fc;
		if (!c[5]) return c[6] ? {6'h00, r} : {8'h00, r[9:2]};
		return {r, 6'h00} ^ {c[4], 15'h0000};
	endfunction
	task automatic conv(logic [7:0] c);
		logic [2:0] ch;
		int t;
		ch = 3'($urandom);
		vin = $urandom_range(1023);
		t = 20 * (c[6] ? 28 : 26);
		wr(adcsq_pkg::ADDR_CTRL, c);
		wr(adcsq_pkg::ADDR_START, {5'h00, ch});
		wirq();
		chk("time", 16'(n >= t - 22 && n <= t + 2), 16'h1);
		chk("mux", 16'(mux_sel), 16'(ch));
		chk("dac", 16'(dac_code), 16'(c[6] ? 10'(vin) : 10'(vin) & 10'h3fc));
		rc("res_hi", adcsq_pkg::ADDR_RES_HI, 8'(fmt(c) >> 8));
		rc("res_lo", adcsq_pkg::ADDR_RES_LO, 8'(fmt(c)));
		rc("done", adcsq_pkg::ADDR_STS, 8'h81 | {1'b0, c[3], 6'h00});
		wr(adcsq_pkg::ADDR_STS, 8'h01);
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		void'($urandom(32'hcedf));
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		for (int a = 0; a < 8; a++) rc("reset", 3'(a), 8'h00);
		p = 8'($urandom);
		wr(adcsq_pkg::ADDR_PIN_EN, p);
		rc("pins", adcsq_pkg::ADDR_PIN_EN, p);
		chk("pin_out", 16'(pin_analog), 16'(p));
		wr(adcsq_pkg::ADDR_START, 8'h05);
		repeat (600) @(posedge mclk);
		rc("no_start", adcsq_pkg::ADDR_STS, 8'h00);
		wr(adcsq_pkg::ADDR_MASK, 8'h03);
		foreach (modes[i]) conv(modes[i]);
		conv(8'hc8);
		wirq();
		rc("cont", adcsq_pkg::ADDR_STS, 8'hc1);
		wr(adcsq_pkg::ADDR_STS, 8'h01);
		repeat (100) @(posedge mclk);
		stop_mode <= 1'b1;
		repeat (5) @(posedge mclk);
		chk("stop_analog", 16'(analog_en), 16'h0);
		stop_mode <= 1'b0;
		repeat (600) @(posedge mclk);
		rc("stop_abort", adcsq_pkg::ADDR_STS, 8'h82);
		rc("ctrl_kept", adcsq_pkg::ADDR_CTRL, 8'hc8);
		wr(adcsq_pkg::ADDR_STS, 8'h02);
		wr(adcsq_pkg::ADDR_START, 8'h02);
		repeat (100) @(posedge mclk);
		wr(adcsq_pkg::ADDR_CTRL, 8'h40);
		rc("pd_abort", adcsq_pkg::ADDR_STS, 8'h02);
		chk("pd_analog", 16'(analog_en), 16'h0);
		wr(adcsq_pkg::ADDR_STS, 8'h02);
		wr(adcsq_pkg::ADDR_CTRL, 8'hc0);
		rc("pu_again", adcsq_pkg::ADDR_STS, 8'h80);
		chk("irq_clr", 16'(irq), 16'h0);
		wr(adcsq_pkg::ADDR_MASK, 8'h00);
		wr(adcsq_pkg::ADDR_START, 8'h01);
		// Clock enable low freezes the sequence, so done must come later
		clk_en <= 1'b0;
		repeat (200) @(posedge mclk);
		clk_en <= 1'b1;
		repeat (400) @(posedge mclk);
		rc("frozen", adcsq_pkg::ADDR_STS, 8'hc0);
		repeat (200) @(posedge mclk);
		chk("irq_mask", 16'(irq), 16'h0);
		rc("done_masked", adcsq_pkg::ADDR_STS, 8'h81);
		final_report();
	end
endmodule
